// >>> logic/auc_uart_top.v
// auc_uart_top.v: three-channel asynchronous serial transceiver, wishbone regs
// assumes serial, clock and cts pins are asynchronous to mclk
`include "auc_regs.vh"
module auc_uart_top (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [2:0]  serialInPin,
  input  wire [2:0]  transferClockPin,
  input  wire [2:0]  clearToSendPin_b,
  input  wire        ch1AltSerialIn,
  input  wire        ch1AltClock,
  input  wire        ch1AltClearToSend_b,
  output reg  [2:0]  serialOutPin,
  output reg  [2:0]  serialOutOe,
  output reg  [2:0]  requestToSend_b,
  output reg         ch1AltSerialOut,
  output reg         ch1AltSerialOutOe,
  output reg         ch1AltRequestToSend_b,
  output reg  [2:0]  txIrq,
  output reg  [2:0]  rxIrq
);
  localparam RX_IDLE  = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA  = 3'h2;
  localparam RX_PAR   = 3'h3;
  localparam RX_STOP  = 3'h4;

  function hit;
    input [7:0] a;
    input [1:0] ch;
    input [7:0] off;
    hit = (a == (`AUC_CH_SPAN * {6'h00, ch}) + off);
  endfunction

  function [8:0] charMask;
    input [2:0] md;
    case (md)
      `AUC_MODE_7B: charMask = 9'h07F;
      `AUC_MODE_8B: charMask = 9'h0FF;
      default:      charMask = 9'h1FF;
    endcase
  endfunction

  function [8:0] orderBits;
    input [8:0] d;
    input       msb;
    orderBits = msb ? {1'b0, d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]} : d;
  endfunction

  reg  [11:0] pinMeta_ff;
  reg  [11:0] pinSync_ff;
  reg  [7:0]  brg_ff [0:2];
  reg  [7:0]  mr_ff [0:2];
  reg  [7:0]  c0_ff [0:2];
  reg  [7:0]  c1_ff [0:2];
  reg  [7:0]  smr_ff [0:3];
  reg  [7:0]  shCtl_ff;
  reg         remap_ff;
  reg  [31:0] nxt_rdData;
  wire        busReq;
  wire        busWr;
  wire        busRd;
  wire [47:0] rbWord;
  wire [2:0]  shiftEmpty;
  wire [2:0]  bufEmpty;
  wire [2:0]  rxFullW;
  wire [2:0]  pinV;
  wire [2:0]  oeV;
  wire [2:0]  rtsV;
  wire [2:0]  txIrqN;
  wire [2:0]  rxIrqN;
  integer     n;

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pinMeta_ff <= `AUC_RST_PINS;
      pinSync_ff <= `AUC_RST_PINS;
    end
    else
    begin
      pinMeta_ff <= {ch1AltClearToSend_b, ch1AltClock, ch1AltSerialIn,
                     clearToSendPin_b, transferClockPin, serialInPin};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // write and read take effect at the edge where ack is seen high
  assign busReq = wb_cyc_i & wb_stb_i;
  assign busWr  = busReq & wb_ack_o & wb_we_i;
  assign busRd  = busReq & wb_ack_o & ~wb_we_i;

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      for (n = 0; n < 3; n = n + 1)
      begin
        brg_ff[n] <= `AUC_RST_CFG;
        mr_ff[n]  <= `AUC_RST_CFG;
        c0_ff[n]  <= `AUC_RST_CFG;
        c1_ff[n]  <= `AUC_RST_CFG;
      end
      for (n = 0; n < 4; n = n + 1)
        smr_ff[n] <= `AUC_RST_CFG;
      shCtl_ff <= `AUC_RST_CFG;
      remap_ff <= 1'b0;
    end
    else if (busWr && wb_sel_i[0])
    begin
      for (n = 0; n < 3; n = n + 1)
      begin
        if (hit(wb_adr_i, n[1:0], `AUC_OFF_BRG))
          brg_ff[n] <= wb_dat_i[7:0];
        if (hit(wb_adr_i, n[1:0], `AUC_OFF_MR))
          mr_ff[n] <= wb_dat_i[7:0];
        if (hit(wb_adr_i, n[1:0], `AUC_OFF_C0))
          c0_ff[n] <= wb_dat_i[7:0];
        if (hit(wb_adr_i, n[1:0], `AUC_OFF_C1))
          c1_ff[n] <= wb_dat_i[7:0];
      end
      for (n = 0; n < 4; n = n + 1)
        if (hit(wb_adr_i, 2'h0, `AUC_OFF_SMR + {n[5:0], 2'h0}))
          smr_ff[n] <= wb_dat_i[7:0];
      if (hit(wb_adr_i, 2'h0, `AUC_OFF_SHCTL))
        shCtl_ff <= wb_dat_i[7:0];
      if (hit(wb_adr_i, 2'h0, `AUC_OFF_REMAP))
        remap_ff <= wb_dat_i[0];
    end
  end

  // unmapped and write-only addresses read as zero
  always @*
  begin
    nxt_rdData = 32'h0000_0000;
    for (n = 0; n < 3; n = n + 1)
    begin
      if (hit(wb_adr_i, n[1:0], `AUC_OFF_RB))
        nxt_rdData = {16'h0000, rbWord[16*n +: 16]};
      if (hit(wb_adr_i, n[1:0], `AUC_OFF_BRG))
        nxt_rdData = {24'h00_0000, brg_ff[n]};
      if (hit(wb_adr_i, n[1:0], `AUC_OFF_MR))
        nxt_rdData = {24'h00_0000, mr_ff[n]};
      if (hit(wb_adr_i, n[1:0], `AUC_OFF_C0))
        nxt_rdData = {24'h00_0000, c0_ff[n][7:4], shiftEmpty[n], c0_ff[n][2:0]};
      if (hit(wb_adr_i, n[1:0], `AUC_OFF_C1))
        nxt_rdData = {24'h00_0000, c1_ff[n][7:4], rxFullW[n], c1_ff[n][2],
                      bufEmpty[n], c1_ff[n][0]};
    end
    for (n = 0; n < 4; n = n + 1)
      if (hit(wb_adr_i, 2'h0, `AUC_OFF_SMR + {n[5:0], 2'h0}))
        nxt_rdData = {24'h00_0000, smr_ff[n]};
    if (hit(wb_adr_i, 2'h0, `AUC_OFF_SHCTL))
      nxt_rdData = {24'h00_0000, shCtl_ff};
    if (hit(wb_adr_i, 2'h0, `AUC_OFF_REMAP))
      nxt_rdData = {31'h0000_0000, remap_ff};
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq & ~wb_ack_o;
      if (busReq && !wb_ack_o)
        wb_dat_o <= nxt_rdData;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : chan
      localparam [1:0] CH = gi;
      wire [2:0]  md       = mr_ff[gi][2:0];
      wire        modeOk   = (md == `AUC_MODE_7B) | (md == `AUC_MODE_8B)
                           | (md == `AUC_MODE_9B);
      wire [8:0]  mask     = charMask(md);
      wire [3:0]  nBits    = (md == `AUC_MODE_7B) ? 4'h7
                           : (md == `AUC_MODE_8B) ? 4'h8 : 4'h9;
      wire        msbFirst = c0_ff[gi][`AUC_C0_BIT_ORD] & (md == `AUC_MODE_8B);
      wire [8:0]  invMask  = ((gi == 2) && c1_ff[gi][`AUC_C1_DATA_INV]) ? mask
                           : 9'h000;
      wire        pol      = (gi == 2) & mr_ff[gi][`AUC_MR_POL_INV];
      wire        alt      = (gi == 1) & remap_ff;
      wire        rxLine   = (alt ? pinSync_ff[9] : pinSync_ff[gi]) ^ pol;
      wire        clkS     = alt ? pinSync_ff[10] : pinSync_ff[3+gi];
      wire        ctsAlt   = remap_ff ? pinSync_ff[11] : pinSync_ff[7];
      wire        ctsS     = ((gi == 0) && shCtl_ff[`AUC_SH_SEP_CTS]) ? ctsAlt
                           : alt ? pinSync_ff[11] : pinSync_ff[6+gi];
      wire        flowOn   = ~c0_ff[gi][`AUC_C0_FLOW_DIS];
      wire        rtsMode  = flowOn & c0_ff[gi][`AUC_C0_FLOW_DIR];
      wire        ctsOk    = ~(flowOn & ~c0_ff[gi][`AUC_C0_FLOW_DIR]) | ~ctsS;
      wire        txEn     = c1_ff[gi][`AUC_C1_TX_EN];
      wire        rxEn     = c1_ff[gi][`AUC_C1_RX_EN];
      wire        stopLen  = mr_ff[gi][`AUC_MR_STOP_LEN];
      wire        parOn    = mr_ff[gi][`AUC_MR_PAR_ON];
      wire        parOdd   = mr_ff[gi][`AUC_MR_PAR_ODD];
      wire        od       = c0_ff[gi][`AUC_C0_OPEN_DRN];
      wire        src      = (gi == 2) ? c1_ff[gi][`AUC_C1_IRQ_SRC]
                                       : shCtl_ff[gi];
      wire        tbWr     = busWr & hit(wb_adr_i, CH, `AUC_OFF_TB);
      wire        rbRd     = busRd & hit(wb_adr_i, CH, `AUC_OFF_RB);
      wire        tick;
      reg  [2:0]  rxSt_ff;
      reg  [3:0]  rxCnt_ff;
      reg  [3:0]  rxBit_ff;
      reg  [8:0]  rxShift_ff;
      reg         rxPar_ff;
      reg         rxFrm_ff;
      reg         rxStop_ff;
      reg         ovrPend_ff;
      reg  [8:0]  rbData_ff;
      reg         ovr_ff;
      reg         frm_ff;
      reg         pty_ff;
      reg         rxFull_ff;
      reg  [8:0]  tbData_ff;
      reg         tbFull_ff;
      reg         txBusy_ff;
      reg  [12:0] txShift_ff;
      reg  [3:0]  txLeft_ff;
      reg  [3:0]  txCnt_ff;
      reg  [12:0] nxt_frame;
      wire        rxLast   = (rxStop_ff == stopLen);
      wire        rxLoad   = tick & (rxSt_ff == RX_STOP) & (rxCnt_ff == `AUC_TICK_LAST)
                           & rxLast & ~ovrPend_ff;
      wire        txBitEnd = txBusy_ff & tick & (txCnt_ff == `AUC_TICK_LAST);
      wire        txGo     = ~txBusy_ff & tbFull_ff & txEn & modeOk & ctsOk;
      wire [8:0]  txd      = (orderBits(tbData_ff, msbFirst) ^ invMask) & mask;
      wire [3:0]  txLen    = 4'h2 + nBits + {3'h0, parOn} + {3'h0, stopLen};
      wire        lineV    = (txBusy_ff ? txShift_ff[0] : 1'b1) ^ pol;

      auc_baud_gen u_baud (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .run       (modeOk),
        .srcSel    (c0_ff[gi][1:0]),
        .extSel    (mr_ff[gi][`AUC_MR_EXT_CLK]),
        .extClk    (clkS),
        .divisor   (brg_ff[gi]),
        .tick16_ff (tick)
      );

      // start bit, data, optional parity, stop bits, lsb of frame first
      always @*
      begin
        nxt_frame = {3'b111, txd | ~mask, 1'b0};
        if (parOn)
          nxt_frame[nBits + 4'h1] = ^txd ^ parOdd;
      end

      always @(posedge mclk)
      begin
        if (!rst_b)
        begin
          tbData_ff  <= `AUC_RST_TB;
          tbFull_ff  <= 1'b0;
          txBusy_ff  <= 1'b0;
          txShift_ff <= 13'h1FFF;
          txLeft_ff  <= 4'h0;
          txCnt_ff   <= 4'h0;
        end
        else
        begin
          tbFull_ff <= tbWr | (tbFull_ff & ~txGo);
          if (tbWr && wb_sel_i[0])
            tbData_ff[7:0] <= wb_dat_i[7:0];
          if (tbWr && wb_sel_i[1])
            tbData_ff[8] <= wb_dat_i[8];
          if (txGo)
          begin
            txBusy_ff  <= 1'b1;
            txShift_ff <= nxt_frame;
            txLeft_ff  <= txLen;
            txCnt_ff   <= 4'h0;
          end
          else if (!modeOk)
            txBusy_ff <= 1'b0;
          else if (txBusy_ff && tick)
          begin
            txCnt_ff <= txCnt_ff + 4'h1;
            if (txBitEnd)
            begin
              txShift_ff <= {1'b1, txShift_ff[12:1]};
              txLeft_ff  <= txLeft_ff - 4'h1;
              if (txLeft_ff == 4'h1)
                txBusy_ff <= 1'b0;
            end
          end
        end
      end

      always @(posedge mclk)
      begin
        if (!rst_b)
        begin
          rxSt_ff    <= RX_IDLE;
          rxCnt_ff   <= 4'h0;
          rxBit_ff   <= 4'h0;
          rxShift_ff <= 9'h000;
          rxPar_ff   <= 1'b0;
          rxFrm_ff   <= 1'b0;
          rxStop_ff  <= 1'b0;
          ovrPend_ff <= 1'b0;
          rbData_ff  <= 9'h000;
          ovr_ff     <= 1'b0;
          frm_ff     <= 1'b0;
          pty_ff     <= 1'b0;
          rxFull_ff  <= 1'b0;
        end
        else if (!rxEn)
        begin
          rxSt_ff   <= RX_IDLE;
          rxFull_ff <= 1'b0;
          ovr_ff    <= 1'b0;
          frm_ff    <= 1'b0;
          pty_ff    <= 1'b0;
        end
        else
        begin
          if (rbRd)
            rxFull_ff <= 1'b0;
          if (tick)
          begin
            rxCnt_ff <= rxCnt_ff + 4'h1;
            case (rxSt_ff)
              RX_IDLE:
              begin
                rxCnt_ff <= 4'h0;
                if (!rxLine && modeOk)
                begin
                  rxSt_ff    <= RX_START;
                  rxShift_ff <= 9'h000;
                  rxFrm_ff   <= 1'b0;
                end
              end
              RX_START:
              begin
                if (rxCnt_ff == `AUC_TICK_MID)
                begin
                  rxCnt_ff <= 4'h0;
                  rxBit_ff <= 4'h0;
                  rxSt_ff  <= rxLine ? RX_IDLE : RX_DATA;
                end
              end
              RX_DATA:
              begin
                if (rxCnt_ff == `AUC_TICK_LAST)
                begin
                  rxShift_ff[rxBit_ff] <= rxLine;
                  rxBit_ff <= rxBit_ff + 4'h1;
                  if (rxBit_ff == nBits - 4'h1)
                  begin
                    rxSt_ff    <= parOn ? RX_PAR : RX_STOP;
                    rxStop_ff  <= 1'b0;
                    ovrPend_ff <= rxFull_ff & ~stopLen & ~parOn;
                  end
                end
              end
              RX_PAR:
              begin
                if (rxCnt_ff == `AUC_TICK_LAST)
                begin
                  rxPar_ff   <= rxLine;
                  rxSt_ff    <= RX_STOP;
                  rxStop_ff  <= 1'b0;
                  ovrPend_ff <= rxFull_ff & ~stopLen;
                end
              end
              RX_STOP:
              begin
                if (rxCnt_ff == `AUC_TICK_LAST)
                begin
                  rxFrm_ff <= rxFrm_ff | ~rxLine;
                  if (!rxLast)
                  begin
                    rxStop_ff  <= 1'b1;
                    ovrPend_ff <= rxFullW[gi];
                  end
                  else
                  begin
                    rxSt_ff <= RX_IDLE;
                    if (ovrPend_ff)
                      ovr_ff <= 1'b1;
                    else
                    begin
                      rbData_ff <= orderBits(rxShift_ff, msbFirst) ^ invMask;
                      frm_ff    <= rxFrm_ff | ~rxLine;
                      pty_ff    <= parOn & (^rxShift_ff ^ rxPar_ff ^ parOdd);
                      rxFull_ff <= 1'b1;
                    end
                  end
                end
              end
              default:
                rxSt_ff <= RX_IDLE;
            endcase
          end
        end
      end

      assign rbWord[16*gi +: 16] = {ovr_ff | frm_ff | pty_ff, pty_ff, frm_ff, ovr_ff,
                                    3'h0, rbData_ff};
      assign shiftEmpty[gi] = ~txBusy_ff;
      assign bufEmpty[gi]   = ~tbFull_ff;
      assign rxFullW[gi]    = rxFull_ff;
      assign pinV[gi]       = od ? 1'b0 : lineV;
      assign oeV[gi]        = od ? ~lineV : 1'b1;
      assign rtsV[gi]       = ~(rtsMode & rxEn & ~rxFull_ff);
      assign txIrqN[gi]     = src ? (txBitEnd & (txLeft_ff == 4'h1)) : txGo;
      assign rxIrqN[gi]     = rxLoad;
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      serialOutPin          <= 3'h7;
      serialOutOe           <= 3'h7;
      requestToSend_b       <= 3'h7;
      ch1AltSerialOut       <= 1'b1;
      ch1AltSerialOutOe     <= 1'b0;
      ch1AltRequestToSend_b <= 1'b1;
      txIrq                 <= 3'h0;
      rxIrq                 <= 3'h0;
    end
    else
    begin
      serialOutPin          <= pinV & ~{1'b0, remap_ff, 1'b0};
      serialOutOe           <= oeV & ~{1'b0, remap_ff, 1'b0};
      requestToSend_b       <= rtsV | {1'b0, remap_ff, 1'b0};
      ch1AltSerialOut       <= remap_ff ? pinV[1] : 1'b1;
      ch1AltSerialOutOe     <= remap_ff & oeV[1];
      ch1AltRequestToSend_b <= remap_ff ? rtsV[1] : 1'b1;
      txIrq                 <= txIrqN;
      rxIrq                 <= rxIrqN;
    end
  end
endmodule

// >>> logic/auc_regs.vh
// auc_regs.vh: register map, field positions and reset values of the uart
// assumes a 32-bit classic wishbone slave, one register per aligned word
`ifndef AUC_REGS_VH
`define AUC_REGS_VH
`define AUC_CH_SPAN      8'h20
`define AUC_OFF_TB       8'h00
`define AUC_OFF_RB       8'h04
`define AUC_OFF_BRG      8'h08
`define AUC_OFF_MR       8'h0C
`define AUC_OFF_C0       8'h10
`define AUC_OFF_C1       8'h14
`define AUC_OFF_SMR      8'h60
`define AUC_OFF_SHCTL    8'h70
`define AUC_OFF_REMAP    8'h74
`define AUC_MR_EXT_CLK   3
`define AUC_MR_STOP_LEN  4
`define AUC_MR_PAR_ODD   5
`define AUC_MR_PAR_ON    6
`define AUC_MR_POL_INV   7
`define AUC_C0_FLOW_DIR  2
`define AUC_C0_FLOW_DIS  4
`define AUC_C0_OPEN_DRN  5
`define AUC_C0_BIT_ORD   7
`define AUC_C1_TX_EN     0
`define AUC_C1_RX_EN     2
`define AUC_C1_IRQ_SRC   4
`define AUC_C1_DATA_INV  6
`define AUC_SH_SEP_CTS   6
`define AUC_MODE_7B      3'h4
`define AUC_MODE_8B      3'h5
`define AUC_MODE_9B      3'h6
`define AUC_CS_F1        2'h0
`define AUC_CS_F8        2'h1
`define AUC_CS_F32       2'h2
`define AUC_RST_CFG      8'h00
`define AUC_RST_TB       9'h000
`define AUC_RST_PINS     12'hFFF
`define AUC_TICK_MID     4'h7
`define AUC_TICK_LAST    4'hF
`endif

// >>> logic/auc_baud_gen.v
// auc_baud_gen.v: count source select, divisor and 16x bit-rate tick
// assumes extClk is already synchronised to mclk
module auc_baud_gen (
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       run,
  input  wire [1:0] srcSel,
  input  wire       extSel,
  input  wire       extClk,
  input  wire [7:0] divisor,
  output reg        tick16_ff
);
  `include "auc_regs.vh"

  reg [4:0] pre_ff;
  reg       extDly_ff;
  reg [7:0] div_ff;
  reg       srcTick;
  wire      cntTick;

  always @*
  begin
    case (srcSel)
      `AUC_CS_F1:  srcTick = 1'b1;
      `AUC_CS_F8:  srcTick = (pre_ff[2:0] == 3'h7);
      `AUC_CS_F32: srcTick = (pre_ff == 5'h1F);
      default:     srcTick = pre_ff[0];
    endcase
  end

  assign cntTick = extSel ? (extClk & ~extDly_ff) : srcTick;

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pre_ff    <= 5'h00;
      extDly_ff <= 1'b1; // synchroniser resets high, so no false edge
      div_ff    <= 8'h00;
      tick16_ff <= 1'b0;
    end
    else
    begin
      pre_ff    <= pre_ff + 5'h01;
      extDly_ff <= extClk;
      tick16_ff <= 1'b0;
      if (!run)
        div_ff <= 8'h00;
      else if (cntTick)
      begin
        // one tick per divisor+1 source clocks, 16 ticks per bit
        if (div_ff == divisor)
        begin
          div_ff    <= 8'h00;
          tick16_ff <= 1'b1;
        end
        else
          div_ff <= div_ff + 8'h01;
      end
    end
  end
endmodule

// >>> verif/auc_uart_asserts.sv
// auc_uart_asserts.sv: port checks for auc_uart_top
// assumes one mclk domain, rst_b synchronous active low
module auc_uart_asserts (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [2:0]  serialOutPin,
  input wire logic [2:0]  serialOutOe,
  input wire logic [2:0]  requestToSend_b,
  input wire logic [2:0]  txIrq,
  input wire logic [2:0]  rxIrq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence newReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ONE: assert property (newReq |=> ackPulse)
    else $error("ack missing or long");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_DAT_HOLD: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_RST_LINE: assert property (disable iff (1'b0)
    !rst_b |=> &{serialOutPin, serialOutOe, requestToSend_b})
    else $error("lines not idle in reset");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    !rst_b |=> !(|{txIrq, rxIrq, wb_ack_o}))
    else $error("pulse during reset");
  AST_OPEN_DRAIN: assert property ((serialOutPin & ~serialOutOe) == 3'b000)
    else $error("undriven pin high");
  AST_TX_PULSE: assert property ((txIrq & $past(txIrq)) == 3'b000)
    else $error("tx request longer than one cycle");
  AST_RX_PULSE: assert property (rxIrq[0] |=> !rxIrq[0] [*8])
    else $error("rx request repeated");
endmodule

bind auc_uart_top auc_uart_asserts chk (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_dat_o, .serialOutPin, .serialOutOe, .requestToSend_b, .txIrq, .rxIrq);

// >>> verif/auc_line_partner.sv
// auc_line_partner.sv: remote serial device on the channel 0 line
// assumes BIT mclk cycles per bit and a pulled-up transmit line
module auc_line_partner #(
  parameter int BIT = 32
) (
  input  wire logic mclk,
  input  wire logic txLine,
  output logic      rxLine
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rxLine = 1'b1;
  // low start, lsb first, optional parity, stop level chosen
  task automatic sendChar(input logic [8:0] d, input int n, input int par, input logic stp);
    logic b[$];
    b = {1'b0};
    for (int i = 0; i < n; i++) b.push_back(d[i]);
    if (par >= 0) b.push_back(par[0]);
    b.push_back(stp);
    b.push_back(1'b1);
    foreach (b[i])
    begin
      rxLine <= b[i];
      repeat (BIT) @(posedge mclk);
    end
  endtask
  // returns data with stop level at bit n, sampled mid-bit
  task automatic getChar(input int n, output logic [9:0] d, output bit ok);
    int t;
    d = '0;
    t = 0;
    while (txLine !== 1'b0 && t < 40 * BIT)
    begin
      @(posedge mclk);
      t++;
    end
    repeat (BIT / 2) @(posedge mclk);
    ok = t < 40 * BIT && txLine === 1'b0;
    for (int i = 0; i <= n; i++)
    begin
      repeat (BIT) @(posedge mclk);
      d[i] = txLine;
    end
  endtask
endmodule

// >>> verif/tb_auc_uart_top.sv
// tb_auc_uart_top.sv: register and channel 0 serial test of the uart
// assumes divisor 1 on count source f1, so one bit is 32 mclk cycles
`include "auc_regs.vh"
module tb_auc_uart_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = 32;
  logic        mclk, rst_b, wbReq, wbWe, wbAck, rxLine, txLine;
  logic [7:0]  wbAdr;
  logic [31:0] wbDi, wbDo, q;
  logic [2:0]  sOut, sOe, ctsB, rts;
  logic [3:0]  wbSel;
  logic [9:0]  got;
  bit          ok;
  int          mismatches, checked;
  auc_uart_top uut (.mclk, .rst_b, .wb_cyc_i(wbReq), .wb_stb_i(wbReq), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDi), .wb_dat_o(wbDo), .wb_ack_o(wbAck),
    .serialInPin({3{rxLine}}), .transferClockPin(3'h0), .clearToSendPin_b(ctsB),
    .ch1AltSerialIn(rxLine), .ch1AltClock(1'b0), .ch1AltClearToSend_b(1'b1),
    .serialOutPin(sOut), .serialOutOe(sOe), .requestToSend_b(rts), .ch1AltSerialOut(),
    .ch1AltSerialOutOe(), .ch1AltRequestToSend_b(), .txIrq(), .rxIrq());
  auc_line_partner #(.BIT(BIT)) partner (.mclk, .txLine, .rxLine);
  assign txLine = sOe[0] ? sOut[0] : 1'b1;
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    @(posedge mclk);
    wbReq <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDi <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbDo;
    wbReq <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic rxCase(input int par, input logic stp, input logic [7:0] mr,
                        input logic [15:0] exp);
    bus(`AUC_OFF_MR, 1'b1, {24'h0, mr});
    partner.sendChar(9'h03C, 8, par, stp);
    bus(`AUC_OFF_C1, 1'b0, 32'h0);
    chk("rx complete", q & 32'h8, 32'h8);
    bus(`AUC_OFF_RB, 1'b0, 32'h0);
    chk("rx buffer", q, {16'h0, exp});
  endtask
  initial
  begin
    rst_b = 1'b0;
    wbReq = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDi = 32'h0;
    wbSel = 4'hF;
    ctsB = 3'h0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    bus(8'h78, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(`AUC_OFF_BRG, 1'b1, 32'h1);
    bus(`AUC_OFF_BRG, 1'b0, 32'h0);
    chk("divisor", q, 32'h1);
    wbSel <= 4'h0;
    bus(`AUC_OFF_BRG, 1'b1, 32'h33);
    wbSel <= 4'hF;
    bus(`AUC_OFF_BRG, 1'b0, 32'h0);
    chk("divisor sel off", q, 32'h1);
    bus(`AUC_OFF_SHCTL, 1'b1, 32'h0);
    bus(`AUC_OFF_SMR, 1'b1, 32'h0);
    bus(`AUC_OFF_C1, 1'b1, 32'h5);
    for (int m = 4; m <= 6; m++)
    begin
      bus(`AUC_OFF_MR, 1'b1, m);
      bus(`AUC_OFF_TB, 1'b1, 32'h1A5);
      partner.getChar(m + 3, got, ok);
      chk("tx frame", {ok, got}, 1024 + (1 << (m + 3)) + (9'h1A5 & ((1 << (m + 3)) - 1)));
    end
    bus(`AUC_OFF_MR, 1'b1, 32'h5);
    ctsB <= 3'h1;
    bus(`AUC_OFF_TB, 1'b1, 32'h55);
    repeat (BIT / 2) @(posedge mclk);
    chk("cts hold", txLine, 32'h1);
    ctsB <= 3'h0;
    partner.getChar(8, got, ok);
    chk("cts release", {ok, got}, 32'h555);
    bus(`AUC_OFF_C0, 1'b1, 32'hA0);
    bus(`AUC_OFF_TB, 1'b1, 32'h1E);
    partner.getChar(8, got, ok);
    chk("msb first", {ok, got}, 32'h578);
    repeat (BIT) @(posedge mclk);
    bus(`AUC_OFF_C0, 1'b0, 32'h0);
    chk("shift empty", q, 32'hA8);
    bus(`AUC_OFF_C1, 1'b0, 32'h0);
    chk("tx buffer empty", q, 32'h7);
    bus(`AUC_OFF_C0, 1'b1, 32'h0);
    rxCase(-1, 1'b1, 8'h05, 16'h003C);
    rxCase(-1, 1'b0, 8'h05, 16'hA03C);
    rxCase(1, 1'b1, 8'h45, 16'hC03C);
    rxCase(1, 1'b1, 8'h65, 16'h003C);
    partner.sendChar(9'h011, 8, -1, 1'b1);
    rxCase(-1, 1'b1, 8'h05, 16'h9011);
    bus(`AUC_OFF_C0, 1'b1, 32'h4);
    bus(`AUC_OFF_C0, 1'b0, 32'h0);
    chk("rts select", q, 32'hC);
    chk("rts ready", rts, 32'h6);
    end_sim();
  end
endmodule
